/* File: verilog/seconds_counter_regs.svh */
// register offsets, field positions, reset values and timing figures of the seconds counter
`ifndef SECONDS_COUNTER_REGS_SVH
`define SECONDS_COUNTER_REGS_SVH

// register pointer values
`define OFS_COUNT_BYTE0    3'h0
`define OFS_COUNT_BYTE1    3'h1
`define OFS_COUNT_BYTE2    3'h2
`define OFS_COUNT_BYTE3    3'h3
`define OFS_OSC_CONTROL    3'h4
`define OFS_CHARGE_SELECT  3'h5
`define OFS_LAST           3'h5

// field positions
`define OSC_STOP_BIT       7
`define UNLOCK_MSB         7
`define UNLOCK_LSB         4
`define DIODE_MSB          3
`define DIODE_LSB          2
`define RESISTOR_MSB       1
`define RESISTOR_LSB       0

// field values
`define UNLOCK_KEY         4'hA
`define DIODE_NONE         2'h1
`define DIODE_ONE          2'h2
`define RESISTOR_OFF       2'h0

// reset values
`define CHARGE_RESET       8'h00
`define COUNT_RESET        32'h0000_0000
`define OSC_STOP_RESET     1'b0

// timing
`define MCLK_HZ            25000000
`define RELEASE_DELAY_MS   250
`define OSC_START_MS       1000
`define OSC_HZ             32768

`endif

/* File: verilog/seconds_counter_pkg.sv */
// types shared by the seconds counter block
package seconds_counter_pkg;

    // one byte-level request from the serial slave engine
    typedef struct packed {
        logic       xfer_begin;
        logic       addr_set;
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
        logic       rd;
    } reg_req_t;

    // decoded charge path steering
    typedef struct packed {
        logic       enable;
        logic       diode_on;
        logic [1:0] resistor;
    } charge_ctl_t;

    // state of the one-second timebase
    typedef struct packed {
        logic [2:0]  sync;
        logic        level;
        logic [15:0] div;
        logic        tick;
    } tick_state_t;

    // state of the register block
    typedef struct packed {
        logic [2:0]  sup_sync;
        logic        sup_ok;
        logic [2:0]  bak_sync;
        logic        on_backup;
        logic [31:0] count;
        logic [31:0] snap;
        logic [2:0]  ptr;
        logic        osc_stop;
        logic [7:0]  charge;
        charge_ctl_t charge_out;
        logic [31:0] hold;
        logic        rst_active;
        logic [7:0]  rd_data;
        logic        rd_done;
    } regs_state_t;

endpackage : seconds_counter_pkg

/* File: verilog/seconds_tick.sv */
// one-second tick generator from the 32.768 kHz oscillator input
`include "seconds_counter_regs.svh"
module seconds_tick
    import seconds_counter_pkg::*;
#(
    parameter int unsigned OSC_DIV = `OSC_HZ
)(
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic osc_pin,
    input  wire logic osc_run,
    output logic      tick
);
    if (OSC_DIV < 2 || OSC_DIV > 65536)
    begin : g_bad_div
        $error("OSC_DIV out of range");
    end

    localparam logic [15:0] DIV_LAST = 16'(OSC_DIV - 1);

    tick_state_t st_reg;
    tick_state_t st_next;

    // level follows the pin once the last two stages agree
    always_comb
    begin
        st_next      = st_reg;
        st_next.sync = {st_reg.sync[1:0], osc_pin};
        st_next.tick = 1'b0;
        if (st_reg.sync[2] == st_reg.sync[1])
        begin
            st_next.level = st_reg.sync[2];
        end
        // a stopped oscillator makes no edges, so the divider holds
        if (osc_run && st_reg.sync[2] == st_reg.sync[1] && st_reg.sync[2] && !st_reg.level)
        begin
            if (st_reg.div == DIV_LAST)
            begin
                st_next.div  = 16'h0000;
                st_next.tick = 1'b1;
            end
            else
            begin
                st_next.div = st_reg.div + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;

endmodule : seconds_tick

/* File: verilog/seconds_counter_regs.sv */
// register map, supply monitor and charge control of the binary seconds counter
// How it works
// - counter bytes 0..3, least significant first
// - pointer wraps from 05h to 00h
// - control register bit 7 stops oscillator on backup, stops counting always
// - charge register: unlock, diode, resistor fields
// - charge only with unlock pattern 1010
// - charge register resets to zero
// - diode 01 none, 10 one, else off
// - resistor 01/10/11 select, 00 off
// - no register access below trip level
// - supply fail drives reset, blocks access
// - reset held for release delay after recovery
// - stop bit adds oscillator start-up time
// - primary: oscillator runs, counting needs bit 0
// - backup: stop bit halts oscillator, standby
// - backup keeps counting until supply returns
// - counter increments once per second
// - pointer advances after each data byte
// - timebase from 32.768 kHz oscillator
`include "seconds_counter_regs.svh"
module seconds_counter_regs
    import seconds_counter_pkg::*;
#(
    parameter int unsigned RELEASE_DELAY_CYC = `RELEASE_DELAY_MS * (`MCLK_HZ / 1000),
    parameter int unsigned OSC_START_CYC     = `OSC_START_MS * (`MCLK_HZ / 1000),
    parameter int unsigned OSC_DIV           = `OSC_HZ
)(
    input  wire logic  mclk,
    input  wire logic  rst_n,
    input  wire logic  osc_pin,
    input  wire logic  supply_ok_pin,
    input  wire logic  backup_pin,
    input  reg_req_t   req,
    output logic [7:0] rd_data,
    output logic       rd_done,
    output logic       access_ok,
    output logic       osc_run,
    output charge_ctl_t charge_ctl,
    input  wire logic  rst_pin_i,
    output logic       rst_pin_o,
    output logic       rst_pin_oe
);

    if (RELEASE_DELAY_CYC < 1 || OSC_START_CYC < 1)
    begin : g_bad_delay
        $error("delays must be at least one cycle");
    end
    if (64'(RELEASE_DELAY_CYC) + 64'(OSC_START_CYC) > 64'h0000_0000_FFFF_FFFF)
    begin : g_bad_sum
        $error("delays exceed hold counter");
    end

    localparam logic [31:0] REL_CYC = 32'(RELEASE_DELAY_CYC);
    localparam logic [31:0] OSC_CYC = 32'(OSC_START_CYC);

    regs_state_t st_reg;
    regs_state_t st_next;
    logic        tick;

    // oscillator halts only in backup with the stop bit set
    assign osc_run = !(st_reg.on_backup && st_reg.osc_stop);

    seconds_tick #(
        .OSC_DIV (OSC_DIV)
    ) u_tick (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .osc_pin (osc_pin),
        .osc_run (osc_run),
        .tick    (tick)
    );

    // register read mux; counter bytes come from the capture
    function automatic logic [7:0] read_byte(input logic [2:0] p, input regs_state_t s);
        logic [7:0] v;
        v = 8'h00;
        unique case (p)
            `OFS_COUNT_BYTE0:   v = s.snap[7:0];
            `OFS_COUNT_BYTE1:   v = s.snap[15:8];
            `OFS_COUNT_BYTE2:   v = s.snap[23:16];
            `OFS_COUNT_BYTE3:   v = s.snap[31:24];
            `OFS_OSC_CONTROL:   v = {s.osc_stop, 7'h00};
            `OFS_CHARGE_SELECT: v = s.charge;
            default:            v = 8'h00;
        endcase
        return v;
    endfunction : read_byte

    // pointer step with wrap after the last register
    function automatic logic [2:0] next_ptr(input logic [2:0] p);
        return (p >= `OFS_LAST) ? 3'h0 : p + 3'h1;
    endfunction : next_ptr

    // charge path decode from the stored select byte
    function automatic charge_ctl_t decode_charge(input logic [7:0] c);
        charge_ctl_t d;
        logic [3:0]  key;
        logic [1:0]  dio;
        logic [1:0]  res;
        key        = c[`UNLOCK_MSB:`UNLOCK_LSB];
        dio        = c[`DIODE_MSB:`DIODE_LSB];
        res        = c[`RESISTOR_MSB:`RESISTOR_LSB];
        d.enable   = (key == `UNLOCK_KEY)
                     && (dio == `DIODE_NONE || dio == `DIODE_ONE)
                     && (res != `RESISTOR_OFF);
        d.diode_on = d.enable && (dio == `DIODE_ONE);
        d.resistor = d.enable ? res : `RESISTOR_OFF;
        return d;
    endfunction : decode_charge

    // all register, monitor and pointer updates
    always_comb
    begin
        logic [31:0] cnt;
        cnt              = st_reg.count;
        st_next          = st_reg;
        st_next.rd_done  = 1'b0;

        // supply and backup levels settle when two stages agree
        st_next.sup_sync = {st_reg.sup_sync[1:0], supply_ok_pin};
        st_next.bak_sync = {st_reg.bak_sync[1:0], backup_pin};
        if (st_reg.sup_sync[2] == st_reg.sup_sync[1])
        begin
            st_next.sup_ok = st_reg.sup_sync[2];
        end
        if (st_reg.bak_sync[2] == st_reg.bak_sync[1])
        begin
            st_next.on_backup = st_reg.bak_sync[2];
        end

        // seconds count, frozen while the stop bit is set
        if (tick && !st_reg.osc_stop)
        begin
            cnt = st_reg.count + 32'h0000_0001;
        end

        // register access only while supply is above the trip level
        if (st_reg.sup_ok)
        begin
            if (req.xfer_begin || req.addr_set)
            begin
                st_next.snap = st_reg.count;
            end
            if (req.addr_set)
            begin
                st_next.ptr = (req.addr[7:3] == 5'h00 && req.addr[2:0] <= `OFS_LAST)
                              ? req.addr[2:0] : 3'h0;
            end
            else if (req.wr)
            begin
                unique case (st_reg.ptr)
                    `OFS_COUNT_BYTE0:   cnt[7:0]   = req.wdata;
                    `OFS_COUNT_BYTE1:   cnt[15:8]  = req.wdata;
                    `OFS_COUNT_BYTE2:   cnt[23:16] = req.wdata;
                    `OFS_COUNT_BYTE3:   cnt[31:24] = req.wdata;
                    `OFS_OSC_CONTROL:   st_next.osc_stop = req.wdata[`OSC_STOP_BIT];
                    `OFS_CHARGE_SELECT: st_next.charge = req.wdata;
                    default:            st_next.charge = st_reg.charge;
                endcase
                st_next.ptr = next_ptr(st_reg.ptr);
            end
            else if (req.rd)
            begin
                st_next.rd_data = read_byte(st_reg.ptr, st_reg);
                st_next.rd_done = 1'b1;
                st_next.ptr     = next_ptr(st_reg.ptr);
            end
        end // else every strobe is dropped
        st_next.count      = cnt;
        st_next.charge_out = decode_charge(st_reg.charge);

        // reset hold: loaded while supply is low, counted down after
        if (!st_reg.sup_ok)
        begin
            st_next.hold       = REL_CYC + (st_reg.osc_stop ? OSC_CYC : 32'h0000_0000);
            st_next.rst_active = 1'b1;
        end
        else if (st_reg.hold != 32'h0000_0000)
        begin
            st_next.hold       = st_reg.hold - 32'h0000_0001;
            st_next.rst_active = 1'b1;
        end
        else
        begin
            st_next.rst_active = 1'b0;
        end
    end

    // sup_ok resets low so a power-up runs the full release delay
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg            <= '0;
            st_reg.count      <= `COUNT_RESET;
            st_reg.osc_stop   <= `OSC_STOP_RESET;
            st_reg.charge     <= `CHARGE_RESET;
            st_reg.rst_active <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign rd_data    = st_reg.rd_data;
    assign rd_done    = st_reg.rd_done;
    assign access_ok  = st_reg.sup_ok;
    assign charge_ctl = st_reg.charge_out;
    assign rst_pin_o  = 1'b0;
    assign rst_pin_oe = st_reg.rst_active;

    // pointer wraps after the last register
    a_ptr_wrap_write: assert property (@(posedge mclk) disable iff (!rst_n)
        st_reg.sup_ok && !req.addr_set && (req.wr || req.rd) && st_reg.ptr == `OFS_LAST
        |=> st_reg.ptr == 3'h0)
        else $error("pointer did not wrap to zero");

    a_ptr_step: assert property (@(posedge mclk) disable iff (!rst_n)
        st_reg.sup_ok && !req.addr_set && !req.wr && req.rd && st_reg.ptr < `OFS_LAST
        |=> st_reg.ptr == $past(st_reg.ptr) + 3'h1 && rd_done)
        else $error("pointer did not advance after read");

    a_charge_key: assert property (@(posedge mclk) disable iff (!rst_n)
        charge_ctl.enable |-> $past(st_reg.charge[7:4]) == 4'hA)
        else $error("charge enabled without unlock pattern");

    a_diode_gate: assert property (@(posedge mclk) disable iff (!rst_n)
        ($past(st_reg.charge[3:2]) == 2'h0 || $past(st_reg.charge[3:2]) == 2'h3)
        |-> !charge_ctl.enable)
        else $error("charge enabled with illegal diode choice");

    a_resistor_gate: assert property (@(posedge mclk) disable iff (!rst_n)
        charge_ctl.enable |-> charge_ctl.resistor != 2'h0
        && charge_ctl.resistor == $past(st_reg.charge[1:0]))
        else $error("resistor choice not passed through");

    a_blocked_access: assert property (@(posedge mclk) disable iff (!rst_n)
        !st_reg.sup_ok |=> $stable(st_reg.charge) && $stable(st_reg.ptr)
        && $stable(st_reg.osc_stop) && !rd_done)
        else $error("register access while supply low");

    a_reset_on_fail: assert property (@(posedge mclk) disable iff (!rst_n)
        !st_reg.sup_ok |-> !access_ok ##1 rst_pin_oe)
        else $error("reset not driven on supply fail");

    a_release_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(st_reg.sup_ok) |-> rst_pin_oe [*8])
        else $error("reset released too early");

    a_count_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
        st_reg.osc_stop && !(st_reg.sup_ok && req.wr && !req.addr_set)
        |=> $stable(st_reg.count))
        else $error("counter moved with stop bit set");

    a_tick_incr: assert property (@(posedge mclk) disable iff (!rst_n)
        tick && !st_reg.osc_stop && !(st_reg.sup_ok && req.wr)
        |=> st_reg.count == $past(st_reg.count) + 32'h0000_0001)
        else $error("counter did not increment on tick");

    a_osc_standby: assert property (@(posedge mclk) disable iff (!rst_n)
        st_reg.on_backup && st_reg.osc_stop |=> !tick)
        else $error("oscillator running in standby");

    a_snap_capture: assert property (@(posedge mclk) disable iff (!rst_n)
        st_reg.sup_ok && req.xfer_begin |=> st_reg.snap == $past(st_reg.count))
        else $error("counter not captured at transfer start");

    // open-drain pin: the line must read low whenever it is driven
    a_pin_driven_low: assert property (@(posedge mclk) disable iff (!rst_n)
        rst_pin_oe
        |-> !rst_pin_i)
        else $error("reset pin not low while driven");

    // read data stands until the next accepted read
    a_rd_data_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        !(st_reg.sup_ok && req.rd && !req.wr && !req.addr_set)
        |=> $stable(rd_data))
        else $error("read data changed without a read");

    // counter bytes are answered from the capture, not the live count
    a_rd_from_snap: assert property (@(posedge mclk) disable iff (!rst_n)
        st_reg.sup_ok && req.rd && !req.wr && !req.addr_set && st_reg.ptr == 3'h0
        |=> rd_data == $past(st_reg.snap[7:0]))
        else $error("counter byte not read from capture");

    // writes go straight to the live counter, the written byte replaces that byte of a same-cycle tick increment
    a_write_loads: assert property (@(posedge mclk) disable iff (!rst_n)
        st_reg.sup_ok && req.wr && !req.addr_set && st_reg.ptr == 3'h0
        |=> st_reg.count[7:0] == $past(req.wdata))
        else $error("counter write did not load");

    // counting goes on from the backup source while the supply is low
    a_backup_counts: assert property (@(posedge mclk) disable iff (!rst_n)
        tick && !st_reg.osc_stop && !st_reg.sup_ok
        |=> st_reg.count == $past(st_reg.count) + 32'h0000_0001)
        else $error("counter stopped while on backup");

    // reset lets go once the hold count has run out
    a_release_end: assert property (@(posedge mclk) disable iff (!rst_n)
        st_reg.sup_ok && st_reg.hold == 32'h0000_0000
        |=> !rst_pin_oe)
        else $error("reset held after release delay");

    // no disable here: it looks at the release edge of the reset itself
    a_charge_reset: assert property (@(posedge mclk)
        $rose(rst_n)
        |-> st_reg.charge == 8'h00 && !charge_ctl.enable)
        else $error("charge register not cleared by reset");

endmodule : seconds_counter_regs

/* File: tb/bus_master_model.sv */
// bus master model that issues byte strobes to the register block
module bus_master_model
    import seconds_counter_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rd_done,
    input  wire logic [7:0] rd_data,
    output reg_req_t        req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    // one strobe: raised on a falling edge, held across one rising edge
    // kind 0 transfer start, 1 pointer load, 2 write, 3 read
    task automatic strobe(input logic [1:0] kind, input logic [7:0] val);
        @(negedge mclk);
        req.xfer_begin = (kind == 2'h0);
        req.addr_set   = (kind == 2'h1);
        req.wr         = (kind == 2'h2);
        req.rd         = (kind == 2'h3);
        req.addr       = val;
        req.wdata      = val;
        @(negedge mclk);
        req = '0;
    endtask : strobe

    // read strobe, then wait a bounded time for the answer pulse
    task automatic read(output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        strobe(2'h3, 8'h00);
        repeat (3)
        begin
            if (!ok && rd_done === 1'b1)
            begin
                ok = 1'b1;
                d = rd_data;
            end
            @(negedge mclk);
        end
    endtask : read
endmodule : bus_master_model

/* File: tb/seconds_counter_regs_tb.sv */
// self-checking testbench of the seconds counter register block
module seconds_counter_regs_tb;
    import seconds_counter_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned REL = 20;
    localparam int unsigned OSC = 10;
    localparam int          LIMIT = 30000;

    logic        mclk;
    logic        rst_n;
    logic        osc_pin;
    logic        supply_ok_pin;
    logic        backup_pin;
    logic        rst_line;
    logic [7:0]  rd_data;
    logic        rd_done;
    logic        access_ok;
    logic        osc_run;
    logic        rst_pin_o;
    logic        rst_pin_oe;
    charge_ctl_t charge_ctl;
    reg_req_t    req;
    int          errors;
    int          samples_checked;
    int          cycles;

    // open-drain reset line with pull-up
    assign rst_line = rst_pin_oe ? rst_pin_o : 1'b1;

    seconds_counter_regs #(.RELEASE_DELAY_CYC(REL), .OSC_START_CYC(OSC), .OSC_DIV(4)) DUT (
        .mclk(mclk), .rst_n(rst_n), .osc_pin(osc_pin), .supply_ok_pin(supply_ok_pin),
        .backup_pin(backup_pin), .req(req), .rd_data(rd_data), .rd_done(rd_done),
        .access_ok(access_ok), .osc_run(osc_run), .charge_ctl(charge_ctl),
        .rst_pin_i(rst_line), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe));

    bus_master_model master (.mclk(mclk), .rd_done(rd_done), .rd_data(rd_data), .req(req));

    // 25 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // hang guard
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            errors++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // slow pulses near 32.768 kHz; always sent in fours to keep divider phase
    task automatic osc_pulses(input int n);
        repeat (n)
        begin
            repeat (381) @(negedge mclk);
            osc_pin = 1'b1;
            repeat (381) @(negedge mclk);
            osc_pin = 1'b0;
        end
    endtask : osc_pulses

    // bytes go least significant first from the packed value
    task automatic wr_seq(input logic [7:0] a, input int n, input logic [63:0] v);
        master.strobe(2'h1, a);
        for (int i = 0; i < n; i++)
            master.strobe(2'h2, v[8*i +: 8]);
    endtask : wr_seq

    task automatic read_seq(input logic [7:0] a, input int n, input logic [63:0] exp);
        logic [7:0] d;
        logic       ok;
        master.strobe(2'h1, a);
        for (int i = 0; i < n; i++)
        begin
            master.read(d, ok);
            check(ok, 1'b1);
            check(d, exp[8*i +: 8]);
        end
    endtask : read_seq

    // waits for access, then measures how long reset is still pulled
    task automatic wait_release(input int unsigned hold);
        int unsigned n;
        n = 0;
        while (access_ok !== 1'b1 && n < 20)
        begin
            @(negedge mclk);
            n++;
        end
        check(access_ok, 1'b1);
        n = 0;
        while (rst_pin_oe === 1'b1 && n < hold + 8)
        begin
            @(negedge mclk);
            n++;
        end
        check(n + 1 >= hold && n <= hold + 3, 1'b1);
        check(rst_line, 1'b1);
    endtask : wait_release

    task automatic t_map();
        wr_seq(8'h04, 1, 64'h80);
        wr_seq(8'h00, 7, 64'h0078_A580_1234_5611);
        read_seq(8'h00, 7, 64'h0078_A580_1234_5678);
        osc_pulses(4);
        check(osc_run, 1'b1);
        read_seq(8'h00, 4, 64'h1234_5678);
    endtask : t_map

    task automatic t_tick();
        logic [7:0] d;
        logic       ok;
        wr_seq(8'h00, 5, 64'hFF);
        master.strobe(2'h1, 8'h00);
        master.read(d, ok);
        check(d, 8'hFF);
        osc_pulses(4);
        master.read(d, ok);
        check(d, 8'h00);
        master.strobe(2'h0, 8'h00);
        read_seq(8'h00, 4, 64'h0100);
    endtask : t_tick

    // each entry: register value, then expected enable, diode, resistor
    task automatic t_charge();
        logic [11:0] tbl [11] = '{12'hA59, 12'hAAE, 12'hA7B, 12'hABF, 12'hA6A, 12'hA9D,
                                 12'hA40, 12'hA10, 12'hAD0, 12'h550, 12'h250};
        foreach (tbl[i])
        begin
            wr_seq(8'h05, 1, tbl[i][11:4]);
            repeat (2) @(negedge mclk);
            check(charge_ctl, tbl[i][3:0]);
            read_seq(8'h05, 1, tbl[i][11:4]);
        end
    endtask : t_charge

    task automatic t_power(input logic stop);
        logic [7:0] d;
        logic       ok;
        wr_seq(8'h04, 1, {stop, 7'h00});
        wr_seq(8'h05, 1, 64'hA5);
        wr_seq(8'h00, 1, 64'h10);
        supply_ok_pin = 1'b0;
        repeat (8) @(negedge mclk);
        check(access_ok, 1'b0);
        check(rst_line, 1'b0);
        check(osc_run, 1'b1);
        wr_seq(8'h05, 1, 64'h00);
        master.read(d, ok);
        check(ok, 1'b0);
        backup_pin = 1'b1;
        repeat (5) @(negedge mclk);
        check(osc_run, !stop);
        osc_pulses(4);
        backup_pin = 1'b0;
        supply_ok_pin = 1'b1;
        wait_release(stop ? REL + OSC : REL);
        read_seq(8'h05, 1, 64'hA5);
        read_seq(8'h00, 1, stop ? 64'h10 : 64'h11);
    endtask : t_power

    // reset held 20 cycles, then the full release delay before access
    task automatic t_reset();
        repeat (20) @(negedge mclk);
        check(rst_pin_oe, 1'b1);
        check(charge_ctl, 4'h0);
        rst_n = 1'b1;
        wait_release(REL);
        read_seq(8'h04, 2, 64'h0000);
    endtask : t_reset

    // main sequence
    initial
    begin
        errors = 0;
        samples_checked = 0;
        cycles = 0;
        rst_n = 1'b0;
        osc_pin = 1'b0;
        supply_ok_pin = 1'b1;
        backup_pin = 1'b0;
        t_reset();
        t_map();
        t_tick();
        t_charge();
        t_power(1'b1);
        t_power(1'b0);
        final_report();
    end
endmodule : seconds_counter_regs_tb
